/* File: rtl/ljb_pkg.sv */
// Purpose: Shared constants and types for the ladder jump and bit control unit
// Assumes: One instruction is presented per clock while instr_valid is high
// Notes: Opcode and state encodings are fixed here and used by design and bench
`default_nettype none
package ljb_pkg;
    // Jump number field
    localparam int JNUM_W = 7;
    localparam logic [6:0] JNUM_SHARED = 7'h00;
    localparam logic [6:0] JNUM_MAX = 7'h63;
    // Reset value of every data bit and edge history bit
    localparam logic BIT_RST = 1'b0;
    // Default size of the bit image
    localparam int NBITS_DEF = 64;

    // Instruction kinds presented to the unit
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_JUMP_START = 4'h1,
        OP_JUMP_END = 4'h2,
        OP_SET = 4'h3,
        OP_RESET = 4'h4,
        OP_RISE = 4'h5,
        OP_FALL = 4'h6,
        OP_KEEP = 4'h7,
        OP_OUT = 4'h8,
        OP_OUT_NOT = 4'h9,
        OP_GATE = 4'hA,
        OP_GATE_CLR = 4'hB
    } ljb_op_t;

    // Jump sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SKIP = 2'b01
    } ljb_jst_t;
endpackage
`default_nettype wire

/* File: rtl/ljb_exec.sv */
// Purpose: Executes jump and bit control instructions against an internal bit image
// Assumes: Preceding condition logic supplies exec_cond (and keep's second line) per instruction
// Notes: Jump skipping works instruction by instruction; the shared number 00 simply
//        waits for the next jump end 00, so the search costs one cycle per skipped step
//        Program duties (unique numbers, keep line order) are not policed in hardware
`default_nettype none

// Functional notes
// - Jump condition ON runs following instructions normally
// - Jump condition OFF skips, nothing skipped changes
// - Jump number 00..99 selects jump type
// - Numbered jump lands on matching jump end
// - Many jump 00 may share one end
// - Jump 00 resumes after next jump end 00
// - Set and reset act only when condition ON
// - Set turns bit ON, never OFF
// - Reset turns bit OFF, never ON
// - Rising pulse ON one scan after rise
// - Falling pulse ON one scan after fall
// - Next execution clears a produced pulse
// - Keep first line ON sets bit
// - Keep second line ON clears, else hold
// - Keep bit holds inside gated section
// - Gate OFF runs section with conditions OFF
module ljb_exec
    import ljb_pkg::*;
#(
    parameter int NBITS = NBITS_DEF,
    parameter int AW = $clog2(NBITS_DEF)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Program scan boundary
    input wire logic scan_start,
    // Instruction stream
    input wire logic instr_valid,
    input wire ljb_op_t instr_op,
    input wire logic [JNUM_W-1:0] jump_num,
    input wire logic exec_cond,
    input wire logic keep_reset_cond,
    input wire logic [AW-1:0] operand_addr,
    // Bit image and write-back
    output logic [NBITS-1:0] bit_image,
    output logic wr_valid,
    output logic [AW-1:0] wr_addr,
    output logic wr_data,
    // Status
    output logic skipping,
    output logic gated,
    output logic jump_num_err
);

    // Refuse sizes the address cannot reach
    if (NBITS < 2 || (1 << AW) < NBITS) begin : g_size_chk
        $error("ljb_exec: AW too small for NBITS");
    end

    // Instructions that write their operand bit
    function automatic logic is_bit_op(input ljb_op_t op);
        return op inside {OP_SET, OP_RESET, OP_RISE, OP_FALL, OP_KEEP, OP_OUT, OP_OUT_NOT};
    endfunction

    // Jump number lies in the documented 00..99 range
    function automatic logic num_ok(input logic [JNUM_W-1:0] n);
        return n <= JNUM_MAX;
    endfunction

    // New operand value; cond is already forced OFF inside a gated section
    function automatic logic bit_next(input ljb_op_t op, input logic cur, input logic prev,
                                      input logic cond, input logic rcond);
        logic v;
        v = cur;
        case (op)
            OP_SET: v = cond ? 1'b1 : cur;
            OP_RESET: v = cond ? 1'b0 : cur;
            OP_RISE: v = cond & ~prev;
            OP_FALL: v = ~cond & prev;
            OP_KEEP: v = rcond ? 1'b0 : (cond ? 1'b1 : cur);
            OP_OUT: v = cond;
            OP_OUT_NOT: v = ~cond;
            default: v = cur;
        endcase
        return v;
    endfunction

    // Whole module state
    typedef struct packed {
        ljb_jst_t st;
        logic [JNUM_W-1:0] skip_num;
        logic gate_off;
        logic [NBITS-1:0] bits;
        logic [NBITS-1:0] prev;
        logic wr_valid;
        logic [AW-1:0] wr_addr;
        logic wr_data;
        logic num_err;
    } ljb_state_t;

    ljb_state_t q, d;
    logic cond_eff;
    logic run_go;
    logic skip_go;

    // Effective condition and the two sequencer qualifiers
    assign cond_eff = exec_cond & ~q.gate_off;
    assign run_go = instr_valid & ~scan_start & (q.st == ST_RUN);
    assign skip_go = instr_valid & ~scan_start & (q.st == ST_SKIP);

    // Next state
    always_comb begin
        d = q;
        d.wr_valid = 1'b0;
        d.num_err = 1'b0;
        if (scan_start) begin
            // A new scan never inherits a pending skip or a closed gate
            d.st = ST_RUN;
            d.gate_off = 1'b0;
        end else if (instr_valid) begin
            case (q.st)
                ST_SKIP: begin
                    // Everything skipped is ignored, including further jump starts
                    if (instr_op == OP_JUMP_END && jump_num == q.skip_num) begin
                        d.st = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (instr_op == OP_JUMP_START) begin
                        if (!num_ok(jump_num)) begin
                            d.num_err = 1'b1;
                        end else if (!cond_eff) begin
                            d.st = ST_SKIP;
                            d.skip_num = jump_num;
                        end
                    end else if (instr_op == OP_JUMP_END) begin
                        // Jump end in run state only reports a bad number
                        d.num_err = !num_ok(jump_num);
                    end else if (instr_op == OP_GATE) begin
                        d.gate_off = ~exec_cond;
                    end else if (instr_op == OP_GATE_CLR) begin
                        d.gate_off = 1'b0;
                    end else if (is_bit_op(instr_op) && !(instr_op == OP_KEEP && q.gate_off)) begin
                        // Keep is left alone in a gated section so its bit holds
                        d.bits[operand_addr] = bit_next(instr_op, q.bits[operand_addr],
                            q.prev[operand_addr], (instr_op == OP_KEEP) ? exec_cond : cond_eff,
                            keep_reset_cond);
                        d.prev[operand_addr] = cond_eff;
                        d.wr_valid = 1'b1;
                        d.wr_addr = operand_addr;
                        d.wr_data = d.bits[operand_addr];
                    end
                end
                default: d.st = ST_RUN;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{st: ST_RUN, skip_num: '0, gate_off: 1'b0, bits: {NBITS{BIT_RST}},
                   prev: {NBITS{BIT_RST}}, wr_valid: 1'b0, wr_addr: '0, wr_data: 1'b0, num_err: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign bit_image = q.bits;
    assign wr_valid = q.wr_valid;
    assign wr_addr = q.wr_addr;
    assign wr_data = q.wr_data;
    assign skipping = (q.st == ST_SKIP);
    assign gated = q.gate_off;
    assign jump_num_err = q.num_err;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Jump sequencing
    jump_pass_a: assert property (run_go && instr_op == OP_JUMP_START && cond_eff && jump_num <= JNUM_MAX
        |=> !skipping) else $error("jump with ON condition skipped");
    jump_take_a: assert property (run_go && instr_op == OP_JUMP_START && !cond_eff && jump_num <= JNUM_MAX
        |=> skipping && q.skip_num == $past(jump_num)) else $error("jump with OFF condition not taken");
    skip_freeze_a: assert property (skip_go |=> $stable(bit_image) && !wr_valid
        && $stable(gated)) else $error("skipped instruction changed state");
    shared_end_a: assert property (skip_go && instr_op == OP_JUMP_END && jump_num == q.skip_num
        |=> !skipping) else $error("matching jump end did not resume");
    shared_nest_a: assert property (skip_go && instr_op == OP_JUMP_START && q.skip_num == JNUM_SHARED
        |=> skipping && q.skip_num == JNUM_SHARED) else $error("nested shared jump lost its target");
    jump_range_a: assert property (run_go && instr_op == OP_JUMP_START && jump_num > JNUM_MAX
        |=> jump_num_err && !skipping) else $error("bad jump number not flagged");

    // Bit control
    set_hold_a: assert property (run_go && instr_op == OP_SET
        |=> bit_image[$past(operand_addr)] == ($past(cond_eff) | $past(q.bits[operand_addr])))
        else $error("set gave wrong bit");
    reset_hold_a: assert property (run_go && instr_op == OP_RESET
        |=> bit_image[$past(operand_addr)] == (!$past(cond_eff) & $past(q.bits[operand_addr])))
        else $error("reset gave wrong bit");
    rise_once_a: assert property (run_go && instr_op == OP_RISE && cond_eff
        ##1 run_go && instr_op == OP_RISE && operand_addr == $past(operand_addr)
        |=> !bit_image[$past(operand_addr)]) else $error("rising pulse longer than one scan");
    fall_pulse_a: assert property (run_go && instr_op == OP_FALL
        |=> wr_data == ($past(q.prev[operand_addr]) & !$past(cond_eff))) else $error("falling pulse wrong");
    keep_clear_a: assert property (run_go && instr_op == OP_KEEP && !q.gate_off && keep_reset_cond
        |=> !bit_image[$past(operand_addr)]) else $error("keep reset line lost priority");
    keep_gate_a: assert property (run_go && instr_op == OP_KEEP && q.gate_off
        |=> $stable(bit_image) && !wr_valid) else $error("keep changed inside gated section");
    gate_off_a: assert property (run_go && instr_op == OP_GATE && !exec_cond
        |=> gated ##0 (!run_go || instr_op != OP_SET || cond_eff == 1'b0)) else $error("gate did not close");

    // Jump end met in run state does nothing but report its number
    end_noop_a: assert property (run_go && instr_op == OP_JUMP_END
        |=> !skipping && $stable(bit_image) && !wr_valid)
        else $error("jump end in run state had an effect");
    // No error pulse comes out of a skipped instruction
    skip_err_a: assert property (skip_go
        |=> !jump_num_err)
        else $error("skipped instruction raised an error");
    // A numbered skip only ends at its own jump end
    numbered_wait_a: assert property (skip_go && q.skip_num != JNUM_SHARED
        && !(instr_op == OP_JUMP_END && jump_num == q.skip_num)
        |=> skipping && q.skip_num == $past(q.skip_num))
        else $error("numbered skip left early");
    // A shared skip ignores numbered jump ends
    shared_wait_a: assert property (skip_go && q.skip_num == JNUM_SHARED
        && instr_op == OP_JUMP_END && jump_num != JNUM_SHARED
        |=> skipping)
        else $error("shared skip left at wrong end");
    // Out of range jump end is flagged too
    end_range_a: assert property (run_go && instr_op == OP_JUMP_END && !num_ok(jump_num)
        |=> jump_num_err && !skipping)
        else $error("bad jump end number not flagged");
    // Inside a closed gate the jump condition reads OFF, so it is taken
    gated_jump_a: assert property (run_go && instr_op == OP_JUMP_START && q.gate_off
        && num_ok(jump_num)
        |=> skipping)
        else $error("gated jump not taken");
    // A scan boundary reopens everything
    scan_clear_a: assert property (scan_start
        |=> !skipping && !gated && !wr_valid)
        else $error("scan start left state behind");
    // Gate clear and an ON gate leave the section open
    gate_clr_a: assert property (run_go && instr_op == OP_GATE_CLR
        |=> !gated)
        else $error("gate clear did not open");
    gate_open_a: assert property (run_go && instr_op == OP_GATE && exec_cond
        |=> !gated)
        else $error("gate with ON condition closed");

    // Set and reset leave the bit alone for an OFF condition
    set_off_a: assert property (run_go && instr_op == OP_SET && !cond_eff
        |=> $stable(bit_image))
        else $error("set changed bit with OFF condition");
    reset_off_a: assert property (run_go && instr_op == OP_RESET && !cond_eff
        |=> $stable(bit_image))
        else $error("reset changed bit with OFF condition");
    // Rising edge of the condition gives a pulse
    rise_pulse_a: assert property (run_go && instr_op == OP_RISE && cond_eff && !q.prev[operand_addr]
        |=> wr_valid && wr_data)
        else $error("rising pulse missing");
    // ON condition never makes a falling pulse
    fall_quiet_a: assert property (run_go && instr_op == OP_FALL && cond_eff
        |=> wr_valid && !wr_data)
        else $error("falling pulse while condition ON");
    // A falling pulse lasts one execution only
    fall_once_a: assert property (run_go && instr_op == OP_FALL && !cond_eff && q.prev[operand_addr]
        ##1 run_go && instr_op == OP_FALL && operand_addr == $past(operand_addr)
        |=> !bit_image[$past(operand_addr)])
        else $error("falling pulse longer than one scan");
    // Keep set line alone turns the bit ON
    keep_set_a: assert property (run_go && instr_op == OP_KEEP && !q.gate_off
        && exec_cond && !keep_reset_cond
        |=> bit_image[$past(operand_addr)])
        else $error("keep set line ignored");
    // Keep with both lines OFF holds the bit
    keep_hold_a: assert property (run_go && instr_op == OP_KEEP && !q.gate_off
        && !exec_cond && !keep_reset_cond
        |=> bit_image[$past(operand_addr)] == $past(q.bits[operand_addr]))
        else $error("keep lost its state");
    // Plain outputs follow the effective condition, so a gate drives OP_OUT OFF and OP_OUT_NOT ON
    out_follow_a: assert property (run_go && instr_op == OP_OUT
        |=> wr_valid && wr_data == $past(cond_eff))
        else $error("output bit wrong");
    out_invert_a: assert property (run_go && instr_op == OP_OUT_NOT
        |=> wr_valid && wr_data == !$past(cond_eff))
        else $error("inverted output bit wrong");

    // Main scenarios
    skip_seen_c: cover property (run_go && instr_op == OP_JUMP_START && !cond_eff ##[1:8] !skipping);
    rise_seen_c: cover property (wr_valid && wr_data ##1 wr_valid && !wr_data);
    keep_gate_c: cover property (run_go && instr_op == OP_KEEP && q.gate_off);
    // Several shared jumps in a row ending at one jump end 00
    shared_nest_c: cover property (skip_go && instr_op == OP_JUMP_START && q.skip_num == JNUM_SHARED
        ##[1:8] !skipping);
endmodule
`default_nettype wire

/* File: sim/ladder_jump_and_bit_control_exec_bench.sv */
// Purpose: Self-checking bench for the jump and bit control unit
// Assumes: A reference model in the driver mirrors the documented instruction behaviour
// Notes: Every instruction leaves a note that the monitor checks one cycle after it is taken
`default_nettype none
module ladder_jump_and_bit_control_exec_bench import ljb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [5:0] a; logic b; logic s; logic g; logic w; logic e;} ljb_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scan_start = 1'b0;
    logic instr_valid = 1'b0;
    logic exec_cond = 1'b0;
    logic keep_reset_cond = 1'b0;
    ljb_op_t instr_op = OP_NOP;
    logic [6:0] jump_num = 7'h00;
    logic [5:0] operand_addr = 6'h00;
    logic [63:0] bit_image;
    logic skipping;
    logic gated;
    logic wr_valid;
    logic [5:0] wr_addr;
    logic wr_data;
    logic jump_num_err;
    logic due_q;
    int bad_count = 0;
    int tests_run = 0;
    // Reference state: bit image, edge history, skip and gate
    logic [63:0] img_m = 64'h0;
    logic [63:0] hist_m = 64'h0;
    logic skip_m = 1'b0;
    logic gate_m = 1'b0;
    logic [6:0] skip_num = 7'h00;
    logic [31:0] seed = 32'h00002C50;
    ljb_note_t notes[$];
    ljb_op_t ops[9] = '{OP_SET, OP_RESET, OP_RISE, OP_FALL, OP_KEEP, OP_OUT, OP_OUT_NOT, OP_JUMP_START, OP_JUMP_END};
    // Numbered jumps stay in the directed part so each number is used once
    logic [6:0] jnums[3] = '{7'h00, 7'h64, 7'h7F};

    always #20 clk = ~clk;

    ljb_exec i_dut (.clk(clk), .rst(rst), .scan_start(scan_start), .instr_valid(instr_valid),
        .instr_op(instr_op), .jump_num(jump_num), .exec_cond(exec_cond), .keep_reset_cond(keep_reset_cond),
        .operand_addr(operand_addr), .bit_image(bit_image), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .skipping(skipping), .gated(gated), .jump_num_err(jump_num_err));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_addr(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Present one instruction and note what the model expects afterwards
    task automatic ex(input ljb_op_t op, input logic [6:0] n, input logic c, input logic r, input logic [5:0] a);
        logic ce;
        logic w;
        logic e;
        @(posedge clk);
        scan_start <= 1'b0;
        instr_valid <= 1'b1;
        instr_op <= op;
        jump_num <= n;
        exec_cond <= c;
        keep_reset_cond <= r;
        operand_addr <= a;
        ce = c & ~gate_m;
        w = 1'b0;
        e = 1'b0;
        if (skip_m) begin
            if (op == OP_JUMP_END && n == skip_num) skip_m = 1'b0;
        end else begin
            w = (op inside {OP_SET, OP_RESET, OP_RISE, OP_FALL, OP_KEEP, OP_OUT, OP_OUT_NOT}) &&
                !(op == OP_KEEP && gate_m);
            e = (op inside {OP_JUMP_START, OP_JUMP_END}) && n > 7'h63;
            case (op)
                OP_JUMP_START: if (n <= 7'h63 && !ce) {skip_m, skip_num} = {1'b1, n};
                OP_SET: if (ce) img_m[a] = 1'b1;
                OP_RESET: if (ce) img_m[a] = 1'b0;
                OP_OUT: img_m[a] = ce;
                OP_OUT_NOT: img_m[a] = ~ce;
                OP_RISE: img_m[a] = ce & ~hist_m[a];
                OP_FALL: img_m[a] = ~ce & hist_m[a];
                OP_KEEP: if (!gate_m) img_m[a] = r ? 1'b0 : (c | img_m[a]);
                OP_GATE: gate_m = ~c;
                OP_GATE_CLR: gate_m = 1'b0;
                default: ;
            endcase
            if (op inside {OP_RISE, OP_FALL}) hist_m[a] = ce;
        end
        notes.push_back('{a, img_m[a], skip_m, gate_m, w, e});
    endtask

    // Scan boundary drops skip and gate state
    task automatic scan();
        @(posedge clk);
        scan_start <= 1'b1;
        instr_valid <= 1'b0;
        skip_m = 1'b0;
        gate_m = 1'b0;
    endtask

    // Monitor: results settle a cycle after the instruction is taken, so look mid-cycle
    always @(posedge clk) due_q <= instr_valid & ~scan_start;
    always @(negedge clk) begin
        ljb_note_t nt;
        if (due_q === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            chk(bit_image[nt.a], nt.b);
            chk(skipping, nt.s);
            chk(gated, nt.g);
            chk(wr_valid, nt.w);
            chk(jump_num_err, nt.e);
            if (nt.w) begin
                chk(wr_data, nt.b);
                chk_addr(wr_addr, nt.a);
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    // Main sequence: directed cases first, then seeded random traffic
    initial begin
        ljb_op_t op;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(bit_image === 64'h0, 1'b1);
        ex(OP_SET, 7'h00, 1'b1, 1'b0, 6'h05);
        ex(OP_SET, 7'h00, 1'b0, 1'b0, 6'h05);
        ex(OP_RESET, 7'h00, 1'b0, 1'b0, 6'h05);
        ex(OP_RESET, 7'h00, 1'b1, 1'b0, 6'h05);
        ex(OP_RISE, 7'h00, 1'b1, 1'b0, 6'h32);
        ex(OP_RISE, 7'h00, 1'b1, 1'b0, 6'h32);
        ex(OP_FALL, 7'h00, 1'b1, 1'b0, 6'h33);
        ex(OP_FALL, 7'h00, 1'b0, 1'b0, 6'h33);
        ex(OP_FALL, 7'h00, 1'b0, 1'b0, 6'h33);
        ex(OP_KEEP, 7'h00, 1'b1, 1'b0, 6'h07);
        ex(OP_KEEP, 7'h00, 1'b0, 1'b0, 6'h07);
        ex(OP_KEEP, 7'h00, 1'b1, 1'b1, 6'h07);
        ex(OP_KEEP, 7'h00, 1'b1, 1'b0, 6'h07);
        ex(OP_GATE, 7'h00, 1'b0, 1'b0, 6'h00);
        ex(OP_KEEP, 7'h00, 1'b0, 1'b1, 6'h07);
        ex(OP_SET, 7'h00, 1'b1, 1'b0, 6'h08);
        ex(OP_GATE_CLR, 7'h00, 1'b0, 1'b0, 6'h00);
        ex(OP_JUMP_START, 7'h64, 1'b0, 1'b0, 6'h00);
        ex(OP_JUMP_START, 7'h04, 1'b1, 1'b0, 6'h00);
        ex(OP_SET, 7'h00, 1'b1, 1'b0, 6'h09);
        ex(OP_JUMP_START, 7'h05, 1'b0, 1'b0, 6'h00);
        ex(OP_SET, 7'h00, 1'b1, 1'b0, 6'h0A);
        ex(OP_JUMP_END, 7'h00, 1'b0, 1'b0, 6'h00);
        ex(OP_JUMP_END, 7'h05, 1'b0, 1'b0, 6'h00);
        ex(OP_JUMP_START, 7'h00, 1'b1, 1'b0, 6'h00);
        ex(OP_JUMP_START, 7'h00, 1'b0, 1'b0, 6'h00);
        ex(OP_JUMP_END, 7'h04, 1'b0, 1'b0, 6'h00);
        ex(OP_JUMP_END, 7'h00, 1'b0, 1'b0, 6'h00);
        for (int i = 0; i < 400; i++) begin
            seed = xs(seed);
            op = ops[seed[3:0] % 9];
            if (seed[10:6] == 5'h00) scan();
            else ex(op, jnums[seed[5:4] % 3], seed[20], seed[21], op inside {OP_RISE, OP_FALL} ?
                {2'b11, seed[27:24]} : {1'b0, seed[28:24]});
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk(notes.size() == 0, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
